// >>> pia_pkg.sv
// Purpose: shared constants for the identifier and advertisement register bank
// Assumes: 16-bit management registers, 5-bit register address
// Notes:   identifier values are module parameters, not held here
package pia_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] PIA_ADDR_CONTROL = 5'h00;
  localparam logic [4:0] PIA_ADDR_STATUS  = 5'h01;
  localparam logic [4:0] PIA_ADDR_ID_HIGH = 5'h02;
  localparam logic [4:0] PIA_ADDR_ID_LOW  = 5'h03;
  localparam logic [4:0] PIA_ADDR_ADVERT  = 5'h04;
  localparam logic [4:0] PIA_ADDR_PHYCTL  = 5'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PIA_CTL_RESTART_BIT  = 9;
  localparam int PIA_STS_EXTCAP_BIT   = 0;
  localparam int PIA_STS_JABBER_BIT   = 1;
  localparam int PIA_STS_ANDONE_BIT   = 5;
  localparam int PIA_ADV_NP_BIT       = 15;
  localparam int PIA_ADV_RF_BIT       = 13;
  localparam int PIA_ADV_ASYM_BIT     = 11;
  localparam int PIA_ADV_PAUSE_BIT    = 10;
  localparam int PIA_ADV_FFD_BIT      = 8;
  localparam int PIA_ADV_FAST_BIT     = 7;
  localparam int PIA_ADV_TFD_BIT      = 6;
  localparam int PIA_ADV_TEN_BIT      = 5;
  localparam int PIA_PCR_TXP_BIT      = 13;
  localparam int PIA_PCR_RXP_BIT      = 12;

  // writable advertisement bits: 15, 13, 11, 10, 8, 7, 6, 5
  localparam logic [15:0] PIA_ADV_WMASK   = 16'hADE0;
  localparam logic [15:0] PIA_ZERO16      = 16'h0000;
  localparam logic        PIA_EXTCAP_VAL  = 1'b1;

endpackage : pia_pkg

// >>> pia_regs.sv
// Purpose: management register bank: status low bits, identifiers, advertisement,
//          restart control bit and pause resolution report
// Assumes: one request per cycle on the register port, inputs synchronous to mclk_i
// Notes:   read data is registered; a read answers one cycle after its strobe
module pia_regs
  import pia_pkg::*;
#(
  parameter int          ADDR_W       = 5,
  parameter logic [15:0] ORG_ID_HIGH  = 16'h5A3C, // arbitrary value
  parameter logic [5:0]  ORG_ID_LOW   = 6'h2D,    // arbitrary value
  parameter logic [5:0]  MODEL_NUMBER = 6'h0B,    // arbitrary value
  parameter logic [3:0]  REVISION     = 4'h6      // arbitrary value
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              srst_i,
  // register port from the management interface
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic              reg_rd_i,
  input  wire logic              reg_wr_i,
  input  wire logic [15:0]       reg_wdata_i,
  output logic      [15:0]       reg_rdata_o,
  output logic                   reg_rvalid_o,
  // strap levels, caught while reset is held
  input  wire logic              strap_fast_fd_i,
  input  wire logic              strap_fast_i,
  input  wire logic              strap_ten_fd_i,
  input  wire logic              strap_ten_i,
  // negotiation engine side
  input  wire logic              jabber_i,
  input  wire logic              neg_complete_i,
  input  wire logic              partner_pause_i,
  input  wire logic              partner_asym_i,
  input  wire logic              restart_ack_i,
  output logic                   restart_req_o,
  output logic      [15:0]       advert_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W != 5) begin : g_bad_addr
    $error("pia_regs: ADDR_W must be 5");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        jabber_latch;
  logic        restart_bit;
  logic [15:0] next_advert;
  logic        rd_status;
  logic        wr_advert;
  logic        wr_control;
  logic        pause_tx;
  logic        pause_rx;
  logic [15:0] next_rdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] want);
    hit = (a == want);
  endfunction : hit

  assign rd_status  = reg_rd_i && hit(reg_addr_i, PIA_ADDR_STATUS);
  assign wr_advert  = reg_wr_i && hit(reg_addr_i, PIA_ADDR_ADVERT);
  assign wr_control = reg_wr_i && hit(reg_addr_i, PIA_ADDR_CONTROL);

  // jabber latch; raw event is latched regardless of speed, software judges it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      jabber_latch <= 1'b0;
    end else if (jabber_i) begin
      jabber_latch <= 1'b1;
    end else if (rd_status) begin
      jabber_latch <= 1'b0;
    end
  end

  // restart request stays up until the engine takes it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      restart_bit <= 1'b0;
    end else if (wr_control && reg_wdata_i[PIA_CTL_RESTART_BIT]) begin
      restart_bit <= 1'b1;
    end else if (restart_ack_i) begin
      restart_bit <= 1'b0;
    end
  end
  assign restart_req_o = restart_bit;

  // advertisement: only writable bits change, reserved and fixed bits stay zero
  always_comb begin
    next_advert = (advert_o & ~PIA_ADV_WMASK) | (reg_wdata_i & PIA_ADV_WMASK);
  end

  // a write before completion is kept as is; renegotiation is software's job
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      advert_o                    <= PIA_ZERO16;
      advert_o[PIA_ADV_FFD_BIT]   <= strap_fast_fd_i;
      advert_o[PIA_ADV_FAST_BIT]  <= strap_fast_i;
      advert_o[PIA_ADV_TFD_BIT]   <= strap_ten_fd_i;
      advert_o[PIA_ADV_TEN_BIT]   <= strap_ten_i;
    end else if (wr_advert) begin
      advert_o <= next_advert;
    end
  end

  // pause resolution, only once negotiation has finished
  always_comb begin
    pause_tx = 1'b0;
    pause_rx = 1'b0;
    if (neg_complete_i) begin
      if (advert_o[PIA_ADV_PAUSE_BIT] && partner_pause_i) begin
        pause_tx = 1'b1;
        pause_rx = 1'b1;
      end else if (!advert_o[PIA_ADV_PAUSE_BIT] && advert_o[PIA_ADV_ASYM_BIT]
                   && partner_pause_i && partner_asym_i) begin
        pause_tx = 1'b1;
      end else if (advert_o[PIA_ADV_PAUSE_BIT] && advert_o[PIA_ADV_ASYM_BIT]
                   && !partner_pause_i && partner_asym_i) begin
        pause_rx = 1'b1;
      end
    end
  end

  // read mux; status reads the latch before this cycle's clear
  always_comb begin
    next_rdata = PIA_ZERO16;
    if (hit(reg_addr_i, PIA_ADDR_CONTROL)) begin
      next_rdata[PIA_CTL_RESTART_BIT] = restart_bit;
    end else if (hit(reg_addr_i, PIA_ADDR_STATUS)) begin
      next_rdata[PIA_STS_EXTCAP_BIT] = PIA_EXTCAP_VAL;
      next_rdata[PIA_STS_JABBER_BIT] = jabber_latch;
      next_rdata[PIA_STS_ANDONE_BIT] = neg_complete_i;
    end else if (hit(reg_addr_i, PIA_ADDR_ID_HIGH)) begin
      next_rdata = ORG_ID_HIGH;
    end else if (hit(reg_addr_i, PIA_ADDR_ID_LOW)) begin
      next_rdata = {ORG_ID_LOW, MODEL_NUMBER, REVISION};
    end else if (hit(reg_addr_i, PIA_ADDR_ADVERT)) begin
      next_rdata = advert_o;
    end else if (hit(reg_addr_i, PIA_ADDR_PHYCTL)) begin
      next_rdata[PIA_PCR_TXP_BIT] = pause_tx;
      next_rdata[PIA_PCR_RXP_BIT] = pause_rx;
    end
  end

  // registered answer; unmapped addresses read zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o  <= PIA_ZERO16;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_JABBER_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
    jabber_latch && !rd_status |=> jabber_latch)
    else $error("jabber flag dropped without a status read");

  AST_JABBER_SET_WINS: assert property (@(posedge mclk_i) disable iff (srst_i)
    jabber_i |=> jabber_latch)
    else $error("jabber event lost");

  AST_JABBER_READ_OLD: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_status |=> reg_rvalid_o && reg_rdata_o[PIA_STS_JABBER_BIT] == $past(jabber_latch))
    else $error("status read did not return pre-clear jabber");

  AST_JABBER_CLEAR: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_status && !jabber_i |=> !jabber_latch)
    else $error("status read did not clear jabber");

  AST_EXTCAP: assert property (@(posedge mclk_i) disable iff (srst_i)
    rd_status |=> reg_rdata_o[PIA_STS_EXTCAP_BIT] && reg_rdata_o[PIA_STS_ANDONE_BIT] == $past(neg_complete_i))
    else $error("status extcap or complete bit wrong");

  AST_ID_LOW: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && hit(reg_addr_i, PIA_ADDR_ID_LOW) |=> reg_rdata_o == {ORG_ID_LOW, MODEL_NUMBER, REVISION})
    else $error("identifier low wrong");

  AST_ID_HIGH: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && hit(reg_addr_i, PIA_ADDR_ID_HIGH) |=> reg_rdata_o == ORG_ID_HIGH)
    else $error("identifier high wrong");

  AST_ADV_FIXED_ZERO: assert property (@(posedge mclk_i) disable iff (srst_i)
    (advert_o & ~PIA_ADV_WMASK) == PIA_ZERO16)
    else $error("fixed advert bits not zero");

  AST_ADV_WRITE: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_advert |=> advert_o == ($past(reg_wdata_i) & PIA_ADV_WMASK))
    else $error("advert write not taken");

  AST_RESTART_SC: assert property (@(posedge mclk_i) disable iff (srst_i)
    restart_bit && restart_ack_i && !wr_control |=> !restart_req_o)
    else $error("restart bit did not self clear");

  AST_PAUSE_SYM: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && hit(reg_addr_i, PIA_ADDR_PHYCTL) && neg_complete_i && advert_o[PIA_ADV_PAUSE_BIT]
      && partner_pause_i |=> reg_rdata_o[PIA_PCR_TXP_BIT +: 1] == 1'b1 && reg_rdata_o[PIA_PCR_RXP_BIT])
    else $error("symmetric pause not resolved");

  // strap levels reach the ability bits on every reset cycle, not only the first
  AST_STRAP_FAST: assert property (@(posedge mclk_i)
    srst_i |=> advert_o[PIA_ADV_FFD_BIT] == $past(strap_fast_fd_i)
      && advert_o[PIA_ADV_FAST_BIT] == $past(strap_fast_i)
      && advert_o[PIA_ADV_TFD_BIT] == $past(strap_ten_fd_i))
    else $error("speed ability straps not loaded");

  AST_STRAP_TEN: assert property (@(posedge mclk_i)
    srst_i |=> advert_o[PIA_ADV_TEN_BIT] == $past(strap_ten_i))
    else $error("ten ability strap not loaded");

  // plain read-write advert flags come back to zero from reset
  AST_RESET_ADV: assert property (@(posedge mclk_i)
    srst_i |=> !advert_o[PIA_ADV_NP_BIT] && !advert_o[PIA_ADV_RF_BIT] && !advert_o[PIA_ADV_ASYM_BIT]
      && !advert_o[PIA_ADV_PAUSE_BIT])
    else $error("advert flags not cleared by reset");

  // reset drops a pending jabber event, a pending restart and the read answer
  AST_RESET_FLAGS: assert property (@(posedge mclk_i)
    srst_i |=> !jabber_latch && !restart_req_o && !reg_rvalid_o)
    else $error("reset left a flag set");

  // a restart write must raise the request on the next cycle
  AST_RESTART_SET: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_control && reg_wdata_i[PIA_CTL_RESTART_BIT] |=> restart_req_o)
    else $error("restart write not taken");

  // identifier low fields checked one by one, so a swapped field shows by name
  AST_ID_MODEL: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && hit(reg_addr_i, PIA_ADDR_ID_LOW)
      |=> reg_rdata_o[$bits(REVISION) +: $bits(MODEL_NUMBER)] == MODEL_NUMBER)
    else $error("model number field wrong");

  AST_ID_REVISION: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && hit(reg_addr_i, PIA_ADDR_ID_LOW)
      |=> reg_rdata_o[$bits(REVISION)-1:0] == REVISION)
    else $error("revision field wrong");

  AST_ID_ORG_LOW: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && hit(reg_addr_i, PIA_ADDR_ID_LOW)
      |=> reg_rdata_o[$bits(reg_rdata_o)-1 -: $bits(ORG_ID_LOW)] == ORG_ID_LOW)
    else $error("org id low field wrong");

  // single advert flags follow the written value
  AST_ADV_NP: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_advert |=> advert_o[PIA_ADV_NP_BIT] == $past(reg_wdata_i[PIA_ADV_NP_BIT]))
    else $error("next page request not written");

  AST_ADV_RF: assert property (@(posedge mclk_i) disable iff (srst_i)
    wr_advert |=> advert_o[PIA_ADV_RF_BIT] == $past(reg_wdata_i[PIA_ADV_RF_BIT]))
    else $error("remote fault advert not written");

  AST_ADV_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
    !wr_advert |=> $stable(advert_o))
    else $error("advert changed without a write");

  // the read path must not expose fixed bits either
  AST_ADV_READ_ZERO: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && hit(reg_addr_i, PIA_ADDR_ADVERT)
      |=> (reg_rdata_o & ~PIA_ADV_WMASK) == PIA_ZERO16)
    else $error("fixed advert bits read as one");

  // asymmetric outcomes: exactly one direction enabled
  AST_PAUSE_TX: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && hit(reg_addr_i, PIA_ADDR_PHYCTL) && neg_complete_i && !advert_o[PIA_ADV_PAUSE_BIT]
      && advert_o[PIA_ADV_ASYM_BIT] && partner_pause_i && partner_asym_i
      |=> reg_rdata_o[PIA_PCR_TXP_BIT] && !reg_rdata_o[PIA_PCR_RXP_BIT])
    else $error("transmit only pause not resolved");

  AST_PAUSE_RX: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && hit(reg_addr_i, PIA_ADDR_PHYCTL) && neg_complete_i && advert_o[PIA_ADV_PAUSE_BIT]
      && advert_o[PIA_ADV_ASYM_BIT] && !partner_pause_i && partner_asym_i
      |=> !reg_rdata_o[PIA_PCR_TXP_BIT] && reg_rdata_o[PIA_PCR_RXP_BIT])
    else $error("receive only pause not resolved");

endmodule : pia_regs

// >>> pia_mgmt_model.sv
// Purpose: management controller model on the register port
// Assumes: strobes move 1 ns after a rising edge
// Notes:   released lines show the inverse of the last value
module pia_mgmt_model
  import pia_pkg::*;
(
  // clock
  input  wire logic        mclk_i,
  // register port
  output logic [4:0]       addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic [15:0]      wdata_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  initial begin
    addr_o = 5'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // one-cycle write; reserved advert bit 12 always sent as zero
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    #1;
    addr_o = a;
    wdata_o = (a == PIA_ADDR_ADVERT) ? (d & 16'hEFFF) : d;
    wr_o = 1'b1;
    @(posedge mclk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr
  // the answer is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(posedge mclk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge mclk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    v = rvalid_i;
    d = rdata_i;
  endtask : rd
endmodule : pia_mgmt_model

// >>> pia_regs_tb.sv
// Purpose: self-checking bench for the register bank
// Assumes: 40 MHz clock, inputs moved 1 ns after the edge
// Notes:   table rows first, then hand-written cases
`define PIA_CHK(n, e, s) \
  checked++; \
  if ((s) !== (e)) begin \
    failures++; \
    $display("wrong value %s exp %h got %h", n, e, s); \
  end
module pia_regs_tb
  import pia_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [4:0]  a;
    logic        w;
    logic [15:0] d;
    logic [15:0] e;
  } pia_row_type;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [4:0]  addr;
  logic        rd;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic        jab = 1'b0;
  logic        done = 1'b0;
  logic        ppause = 1'b0;
  logic        pasym = 1'b0;
  logic        ack = 1'b0;
  logic [3:0]  straps = 4'hA;
  logic        req;
  logic [15:0] adv;
  logic [15:0] q;
  logic        v;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  // read-only places, unmapped address and advert masks
  pia_row_type rows [11] = '{
    '{PIA_ADDR_ID_HIGH, 1'b0, 16'h0000, 16'h5A3C},
    '{PIA_ADDR_ID_LOW, 1'b0, 16'h0000, 16'hB4B6},
    '{PIA_ADDR_ID_HIGH, 1'b1, 16'hFFFF, 16'h5A3C},
    '{PIA_ADDR_STATUS, 1'b1, 16'hFFFF, 16'h0001},
    '{5'h1F, 1'b1, 16'hFFFF, 16'h0000},
    '{PIA_ADDR_ADVERT, 1'b1, 16'hEFFF, 16'hADE0},
    '{PIA_ADDR_ADVERT, 1'b1, 16'h4200, 16'h0000},
    '{PIA_ADDR_ADVERT, 1'b1, 16'hA000, 16'hA000},
    '{PIA_ADDR_ADVERT, 1'b1, 16'h0C00, 16'h0C00},
    '{PIA_ADDR_ADVERT, 1'b1, 16'h01E0, 16'h01E0},
    '{PIA_ADDR_ADVERT, 1'b1, 16'h0000, 16'h0000}
  };
  // ------------------------------------------------------------
  // clock, timeout and verdict
  // ------------------------------------------------------------
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  // pause outcome only counts once negotiation is complete
  task automatic pause(input logic [15:0] d, input logic pp, input logic pa, input logic [15:0] e);
    ppause = pp;
    pasym = pa;
    mgr.wr(PIA_ADDR_ADVERT, d);
    mgr.rd(PIA_ADDR_PHYCTL, q, v);
    `PIA_CHK("phy control", e, q)
  endtask : pause
  pia_mgmt_model mgr (
    .mclk_i   (mclk_i),
    .addr_o   (addr),
    .rd_o     (rd),
    .wr_o     (wr),
    .wdata_o  (wdata),
    .rdata_i  (rdata),
    .rvalid_i (rvalid)
  );
  pia_regs DUT (
    .mclk_i          (mclk_i),
    .srst_i          (srst_i),
    .reg_addr_i      (addr),
    .reg_rd_i        (rd),
    .reg_wr_i        (wr),
    .reg_wdata_i     (wdata),
    .reg_rdata_o     (rdata),
    .reg_rvalid_o    (rvalid),
    .strap_fast_fd_i (straps[3]),
    .strap_fast_i    (straps[2]),
    .strap_ten_fd_i  (straps[1]),
    .strap_ten_i     (straps[0]),
    .jabber_i        (jab),
    .neg_complete_i  (done),
    .partner_pause_i (ppause),
    .partner_asym_i  (pasym),
    .restart_ack_i   (ack),
    .restart_req_o   (req),
    .advert_o        (adv)
  );
  // main sequence
  initial begin
    repeat (8) @(posedge mclk_i);
    #1;
    srst_i = 1'b0;
    `PIA_CHK("advert_o", 16'h0140, adv)
    `PIA_CHK("reg_rvalid_o", 1'b0, rvalid)
    `PIA_CHK("reg_rdata_o", 16'h0000, rdata)
    `PIA_CHK("restart_req_o", 1'b0, req)
    $display("reset done");
    foreach (rows[i]) begin
      if (rows[i].w) begin
        mgr.wr(rows[i].a, rows[i].d);
      end
      mgr.rd(rows[i].a, q, v);
      `PIA_CHK("rvalid", 1'b1, v)
      `PIA_CHK("rdata", rows[i].e, q)
    end
    $display("table done");
    // advert changed before completion, so a restart is requested
    mgr.wr(PIA_ADDR_CONTROL, 16'h0200);
    `PIA_CHK("restart_req_o", 1'b1, req)
    mgr.rd(PIA_ADDR_CONTROL, q, v);
    `PIA_CHK("control", 16'h0200, q)
    @(posedge mclk_i);
    #1;
    ack = 1'b1;
    @(posedge mclk_i);
    #1;
    ack = 1'b0;
    `PIA_CHK("restart_req_o", 1'b0, req)
    `PIA_CHK("reg_rvalid_o", 1'b0, rvalid)
    `PIA_CHK("reg_rdata_o", 16'h0200, rdata)
    $display("restart done");
    // jabber held across the clearing read must survive it
    jab = 1'b1;
    mgr.rd(PIA_ADDR_STATUS, q, v);
    jab = 1'b0;
    `PIA_CHK("status", 16'h0003, q)
    mgr.rd(PIA_ADDR_STATUS, q, v);
    `PIA_CHK("status", 16'h0003, q)
    mgr.rd(PIA_ADDR_STATUS, q, v);
    `PIA_CHK("status", 16'h0001, q)
    $display("jabber done");
    done = 1'b1;
    mgr.rd(PIA_ADDR_STATUS, q, v);
    `PIA_CHK("status", 16'h0021, q)
    pause(16'h0400, 1'b1, 1'b0, 16'h3000);
    pause(16'h0800, 1'b1, 1'b1, 16'h2000);
    pause(16'h0C00, 1'b0, 1'b1, 16'h1000);
    pause(16'h0400, 1'b0, 1'b1, 16'h0000);
    $display("pause done");
    // second reset in mid-run, other strap levels, with events pending
    jab = 1'b1;
    mgr.wr(PIA_ADDR_CONTROL, 16'h0200);
    `PIA_CHK("restart_req_o", 1'b1, req)
    jab = 1'b0;
    straps = 4'h5;
    srst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    srst_i = 1'b0;
    `PIA_CHK("advert_o", 16'h00A0, adv)
    `PIA_CHK("restart_req_o", 1'b0, req)
    `PIA_CHK("reg_rvalid_o", 1'b0, rvalid)
    mgr.rd(PIA_ADDR_STATUS, q, v);
    `PIA_CHK("status", 16'h0021, q)
    mgr.rd(PIA_ADDR_ADVERT, q, v);
    `PIA_CHK("advert", 16'h00A0, q)
    $display("second reset done");
    conclude();
  end
endmodule : pia_regs_tb
